/* File: irqt_cfg.svh */
// Overview of operation
// - Disable-interrupt op writes 0 into the global interrupt enable flag
// - Enable-interrupt op writes 1 into the global interrupt enable flag
// - External-0 enable clear: test skips and clears request flag when it is 1
// - External-0 enable set: the external-0 test acts as a no-operation
// - Level select clear: pin test skips when the interrupt pin is low
// - Level select set: pin test skips when the interrupt pin is high
// - Read op copies interrupt control one into the accumulator
// - Write op copies the accumulator into interrupt control one
// - Read op copies interrupt control two into the accumulator
// - Write op copies the accumulator into interrupt control two
// - Read op copies external interrupt control into the accumulator
// - Write op copies the accumulator into external interrupt control
// - Write-only op copies accumulator bit 0 into auxiliary timer control
// - Timer control one is readable and writable through the accumulator
// - Timer control two is readable and writable through the accumulator
// - Timer control five is readable and writable through the accumulator
// - Timer control six is readable and writable through the accumulator
// - Prescaler read puts count upper nibble in aux, lower in accumulator
// - Prescaler write loads aux and accumulator into count and reload together
// - Timer one read puts count upper nibble in aux, lower in accumulator
// - Timer one write loads aux and accumulator into count and low reload
// - High-reload write loads aux and accumulator, running count untouched
`ifndef IRQT_CFG_SVH
`define IRQT_CFG_SVH
`define IRQT_EXT0_EN_BIT 0
`define IRQT_LVL_SEL_BIT 2
`define IRQT_AUX_CTL_BIT 0
`define IRQT_NIB_RST 4'h0
`define IRQT_FLAG_RST 1'b0
`define IRQT_FLAG_SET 1'b1
`define IRQT_CNT_RST 8'hFF
`define IRQT_RLD_RST 8'hFF
`endif

/* File: irqt_pkg.sv */
package irqt_pkg;
    typedef logic [3:0] irqt_nib_t;
    typedef logic [7:0] irqt_byte_t;
    typedef enum logic [4:0] {
        IRQT_OP_NONE   = 5'h00,
        IRQT_OP_DI     = 5'h01,
        IRQT_OP_EI     = 5'h02,
        IRQT_OP_SKEXT0 = 5'h03,
        IRQT_OP_SKPIN  = 5'h04,
        IRQT_OP_RD_IC1 = 5'h05,
        IRQT_OP_WR_IC1 = 5'h06,
        IRQT_OP_RD_IC2 = 5'h07,
        IRQT_OP_WR_IC2 = 5'h08,
        IRQT_OP_RD_EXC = 5'h09,
        IRQT_OP_WR_EXC = 5'h0A,
        IRQT_OP_WR_AUX = 5'h0B,
        IRQT_OP_RD_TC1 = 5'h0C,
        IRQT_OP_WR_TC1 = 5'h0D,
        IRQT_OP_RD_TC2 = 5'h0E,
        IRQT_OP_WR_TC2 = 5'h0F,
        IRQT_OP_RD_TC5 = 5'h10,
        IRQT_OP_WR_TC5 = 5'h11,
        IRQT_OP_RD_TC6 = 5'h12,
        IRQT_OP_WR_TC6 = 5'h13,
        IRQT_OP_RD_PS  = 5'h14,
        IRQT_OP_WR_PS  = 5'h15,
        IRQT_OP_RD_T1  = 5'h16,
        IRQT_OP_WR_T1  = 5'h17,
        IRQT_OP_WR_T1H = 5'h18
    } irqt_op_e;
endpackage

/* File: irqt_dec_if.sv */
`timescale 1ns/1ps
interface irqt_dec_if;
    logic op_go;
    irqt_pkg::irqt_op_e op;
    logic ext0_en;
    logic lvl_sel;
    logic pin;
    logic ext0_flag;
    logic skip_hit;
    logic ext0_clr;
    modport core (
        output op_go, op, ext0_en, lvl_sel, pin, ext0_flag,
        input skip_hit, ext0_clr
    );
    modport test (
        input op_go, op, ext0_en, lvl_sel, pin, ext0_flag,
        output skip_hit, ext0_clr
    );
endinterface

/* File: irqt_skip_test.sv */
`timescale 1ns/1ps
module irqt_skip_test (
    irqt_dec_if.test dec
);
    logic is_ext0;
    logic is_pin;

    assign is_ext0 = dec.op_go && (dec.op == irqt_pkg::IRQT_OP_SKEXT0);
    assign is_pin = dec.op_go && (dec.op == irqt_pkg::IRQT_OP_SKPIN);

    // Enable set turns the flag test into a no-operation
    always_comb begin
        dec.skip_hit = 1'b0;
        dec.ext0_clr = 1'b0;
        if (is_ext0 && !dec.ext0_en && dec.ext0_flag) begin
            dec.skip_hit = 1'b1;
            dec.ext0_clr = 1'b1;
        end
        if (is_pin) begin
            // Skip when the pin level equals the selected level
            dec.skip_hit = dec.lvl_sel ? dec.pin : !dec.pin;
        end
    end
endmodule

/* File: irqt_reload_cnt.sv */
`timescale 1ns/1ps
`include "irqt_cfg.svh"
module irqt_reload_cnt #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic tick_i,
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    input wire logic [W-1:0] reload_val_i,
    // Status
    output logic [W-1:0] cnt_o,
    output logic under_o
);
    // A load in the same cycle as a tick wins, so software never sees a half-step
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_o <= W'(`IRQT_CNT_RST);
        end else if (load_i) begin
            cnt_o <= load_val_i;
        end else if (tick_i) begin
            cnt_o <= (cnt_o == '0) ? reload_val_i : W'(cnt_o - 1'b1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            under_o <= 1'b0;
        end else begin
            under_o <= !load_i && tick_i && (cnt_o == '0);
        end
    end
endmodule

/* File: irqt_ops.sv */
`timescale 1ns/1ps
`include "irqt_cfg.svh"
module irqt_ops (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Instruction stream
    input wire logic op_valid_i,
    input wire irqt_pkg::irqt_op_e op_i,
    input wire irqt_pkg::irqt_nib_t acc_i,
    input wire irqt_pkg::irqt_nib_t aux_i,
    // External events and pins
    input wire logic ext0_req_i,
    input wire logic ext_irq_pin_i,
    input wire logic prescaler_run_i,
    input wire logic timer_one_run_i,
    // Register file results
    output irqt_pkg::irqt_nib_t acc_o,
    output logic acc_we_o,
    output irqt_pkg::irqt_nib_t aux_o,
    output logic aux_we_o,
    output logic skip_o,
    // Control state
    output logic global_irq_enable_flag_o,
    output logic ext0_request_flag_o,
    output irqt_pkg::irqt_nib_t irq_control_one_o,
    output irqt_pkg::irqt_nib_t irq_control_two_o,
    output irqt_pkg::irqt_nib_t ext_irq_control_o,
    output logic timer_aux_control_o,
    output irqt_pkg::irqt_nib_t timer_control_one_o,
    output irqt_pkg::irqt_nib_t timer_control_two_o,
    output irqt_pkg::irqt_nib_t timer_control_five_o,
    output irqt_pkg::irqt_nib_t timer_control_six_o,
    // Timer state
    output irqt_pkg::irqt_byte_t prescaler_count_o,
    output irqt_pkg::irqt_byte_t prescaler_reload_o,
    output logic prescaler_underflow_o,
    output irqt_pkg::irqt_byte_t timer_one_count_o,
    output irqt_pkg::irqt_byte_t timer_one_low_reload_o,
    output irqt_pkg::irqt_byte_t timer_one_high_reload_o,
    output logic timer_one_underflow_o
);
    irqt_dec_if dec ();

    logic skip_q;
    logic op_go;
    logic irq_en_q;
    logic ext0_flag_q;
    irqt_pkg::irqt_nib_t ic1_q;
    irqt_pkg::irqt_nib_t ic2_q;
    irqt_pkg::irqt_nib_t exc_q;
    logic aux_ctl_q;
    irqt_pkg::irqt_nib_t tc1_q;
    irqt_pkg::irqt_nib_t tc2_q;
    irqt_pkg::irqt_nib_t tc5_q;
    irqt_pkg::irqt_nib_t tc6_q;
    irqt_pkg::irqt_byte_t ps_rld_q;
    irqt_pkg::irqt_byte_t t1l_q;
    irqt_pkg::irqt_byte_t t1h_q;
    irqt_pkg::irqt_nib_t acc_q;
    irqt_pkg::irqt_nib_t aux_q;
    logic acc_we_q;
    logic aux_we_q;
    irqt_pkg::irqt_byte_t ps_cnt;
    irqt_pkg::irqt_byte_t t1_cnt;
    irqt_pkg::irqt_byte_t ab_val;
    logic ps_under;
    logic t1_under;
    logic ps_load;
    logic t1_load;
    logic t1_tick;

    // A word in the shadow of a skip still retires, but changes nothing
    assign op_go = op_valid_i && !skip_q;
    assign ab_val = {aux_i, acc_i};
    assign ps_load = op_go && (op_i == irqt_pkg::IRQT_OP_WR_PS);
    assign t1_load = op_go && (op_i == irqt_pkg::IRQT_OP_WR_T1);
    // Timer one steps on prescaler underflow, so it lags the prescaler by a cycle
    assign t1_tick = ps_under && timer_one_run_i;

    assign dec.op_go = op_go;
    assign dec.op = op_i;
    assign dec.ext0_en = ic1_q[`IRQT_EXT0_EN_BIT];
    assign dec.lvl_sel = exc_q[`IRQT_LVL_SEL_BIT];
    assign dec.pin = ext_irq_pin_i;
    assign dec.ext0_flag = ext0_flag_q;

    irqt_skip_test u_skip (
        .dec(dec.test)
    );

    irqt_reload_cnt #(.W(8)) u_prescaler (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tick_i(prescaler_run_i),
        .load_i(ps_load),
        .load_val_i(ab_val),
        .reload_val_i(ps_rld_q),
        .cnt_o(ps_cnt),
        .under_o(ps_under)
    );

    irqt_reload_cnt #(.W(8)) u_timer_one (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tick_i(t1_tick),
        .load_i(t1_load),
        .load_val_i(ab_val),
        .reload_val_i(t1l_q),
        .cnt_o(t1_cnt),
        .under_o(t1_under)
    );

    // Skip state: only a retiring word moves it, so stalls keep the pending skip
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            skip_q <= `IRQT_FLAG_RST;
        end else if (op_valid_i) begin
            skip_q <= op_go && dec.skip_hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_en_q <= `IRQT_FLAG_RST;
        end else if (op_go && op_i == irqt_pkg::IRQT_OP_DI) begin
            irq_en_q <= `IRQT_FLAG_RST;
        end else if (op_go && op_i == irqt_pkg::IRQT_OP_EI) begin
            irq_en_q <= `IRQT_FLAG_SET;
        end
    end

    // A request arriving with the clearing test is kept: set wins
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ext0_flag_q <= `IRQT_FLAG_RST;
        end else if (ext0_req_i) begin
            ext0_flag_q <= `IRQT_FLAG_SET;
        end else if (dec.ext0_clr) begin
            ext0_flag_q <= `IRQT_FLAG_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ic1_q <= `IRQT_NIB_RST;
            ic2_q <= `IRQT_NIB_RST;
            exc_q <= `IRQT_NIB_RST;
        end else if (op_go) begin
            if (op_i == irqt_pkg::IRQT_OP_WR_IC1) begin
                ic1_q <= acc_i;
            end
            if (op_i == irqt_pkg::IRQT_OP_WR_IC2) begin
                ic2_q <= acc_i;
            end
            if (op_i == irqt_pkg::IRQT_OP_WR_EXC) begin
                exc_q <= acc_i;
            end
        end
    end

    // Only one bit of auxiliary control exists; upper accumulator bits are dropped
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            aux_ctl_q <= `IRQT_FLAG_RST;
        end else if (op_go && op_i == irqt_pkg::IRQT_OP_WR_AUX) begin
            aux_ctl_q <= acc_i[`IRQT_AUX_CTL_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tc1_q <= `IRQT_NIB_RST;
            tc2_q <= `IRQT_NIB_RST;
            tc5_q <= `IRQT_NIB_RST;
            tc6_q <= `IRQT_NIB_RST;
        end else if (op_go) begin
            if (op_i == irqt_pkg::IRQT_OP_WR_TC1) begin
                tc1_q <= acc_i;
            end
            if (op_i == irqt_pkg::IRQT_OP_WR_TC2) begin
                tc2_q <= acc_i;
            end
            if (op_i == irqt_pkg::IRQT_OP_WR_TC5) begin
                tc5_q <= acc_i;
            end
            if (op_i == irqt_pkg::IRQT_OP_WR_TC6) begin
                tc6_q <= acc_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ps_rld_q <= `IRQT_RLD_RST;
            t1l_q <= `IRQT_RLD_RST;
            t1h_q <= `IRQT_RLD_RST;
        end else if (op_go) begin
            if (op_i == irqt_pkg::IRQT_OP_WR_PS) begin
                ps_rld_q <= ab_val;
            end
            if (op_i == irqt_pkg::IRQT_OP_WR_T1) begin
                t1l_q <= ab_val;
            end
            if (op_i == irqt_pkg::IRQT_OP_WR_T1H) begin
                t1h_q <= ab_val;
            end
        end
    end

    // Reads return the value before any write in the same cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            acc_q <= `IRQT_NIB_RST;
            aux_q <= `IRQT_NIB_RST;
            acc_we_q <= 1'b0;
            aux_we_q <= 1'b0;
        end else begin
            acc_we_q <= 1'b0;
            aux_we_q <= 1'b0;
            if (op_go) begin
                unique case (op_i)
                    irqt_pkg::IRQT_OP_RD_IC1: begin
                        acc_q <= ic1_q;
                        acc_we_q <= 1'b1;
                    end
                    irqt_pkg::IRQT_OP_RD_IC2: begin
                        acc_q <= ic2_q;
                        acc_we_q <= 1'b1;
                    end
                    irqt_pkg::IRQT_OP_RD_EXC: begin
                        acc_q <= exc_q;
                        acc_we_q <= 1'b1;
                    end
                    irqt_pkg::IRQT_OP_RD_TC1: begin
                        acc_q <= tc1_q;
                        acc_we_q <= 1'b1;
                    end
                    irqt_pkg::IRQT_OP_RD_TC2: begin
                        acc_q <= tc2_q;
                        acc_we_q <= 1'b1;
                    end
                    irqt_pkg::IRQT_OP_RD_TC5: begin
                        acc_q <= tc5_q;
                        acc_we_q <= 1'b1;
                    end
                    irqt_pkg::IRQT_OP_RD_TC6: begin
                        acc_q <= tc6_q;
                        acc_we_q <= 1'b1;
                    end
                    irqt_pkg::IRQT_OP_RD_PS: begin
                        {aux_q, acc_q} <= ps_cnt;
                        acc_we_q <= 1'b1;
                        aux_we_q <= 1'b1;
                    end
                    irqt_pkg::IRQT_OP_RD_T1: begin
                        {aux_q, acc_q} <= t1_cnt;
                        acc_we_q <= 1'b1;
                        aux_we_q <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    assign acc_o = acc_q;
    assign acc_we_o = acc_we_q;
    assign aux_o = aux_q;
    assign aux_we_o = aux_we_q;
    assign skip_o = skip_q;
    assign global_irq_enable_flag_o = irq_en_q;
    assign ext0_request_flag_o = ext0_flag_q;
    assign irq_control_one_o = ic1_q;
    assign irq_control_two_o = ic2_q;
    assign ext_irq_control_o = exc_q;
    assign timer_aux_control_o = aux_ctl_q;
    assign timer_control_one_o = tc1_q;
    assign timer_control_two_o = tc2_q;
    assign timer_control_five_o = tc5_q;
    assign timer_control_six_o = tc6_q;
    assign prescaler_count_o = ps_cnt;
    assign prescaler_reload_o = ps_rld_q;
    assign prescaler_underflow_o = ps_under;
    assign timer_one_count_o = t1_cnt;
    assign timer_one_low_reload_o = t1l_q;
    assign timer_one_high_reload_o = t1h_q;
    assign timer_one_underflow_o = t1_under;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_skip_taken;
        skip_q ##0 op_valid_i;
    endsequence

    sequence s_ps_write;
        op_go ##0 (op_i == irqt_pkg::IRQT_OP_WR_PS);
    endsequence

    a_di_clears_enable: assert property (
        op_go && op_i == irqt_pkg::IRQT_OP_DI |=> !irq_en_q ##1 (!irq_en_q || $past(op_go)))
        else $error("interrupt enable not cleared");

    a_ei_sets_enable: assert property (
        op_go && op_i == irqt_pkg::IRQT_OP_EI |=> irq_en_q)
        else $error("interrupt enable not set");

    a_ext0_skip_clear: assert property (
        op_go && op_i == irqt_pkg::IRQT_OP_SKEXT0 && !ic1_q[`IRQT_EXT0_EN_BIT]
        && ext0_flag_q && !ext0_req_i |=> skip_q && !ext0_flag_q)
        else $error("external-0 test did not skip and clear");

    a_ext0_nop_case: assert property (
        op_go && op_i == irqt_pkg::IRQT_OP_SKEXT0 && ic1_q[`IRQT_EXT0_EN_BIT]
        |=> !skip_q && (ext0_flag_q == ($past(ext0_flag_q) || $past(ext0_req_i))))
        else $error("external-0 test not a no-operation");

    a_pin_low_skip: assert property (
        op_go && op_i == irqt_pkg::IRQT_OP_SKPIN && !exc_q[`IRQT_LVL_SEL_BIT]
        |=> skip_q == !$past(ext_irq_pin_i))
        else $error("pin test wrong with low level selected");

    a_pin_high_skip: assert property (
        op_go && op_i == irqt_pkg::IRQT_OP_SKPIN && exc_q[`IRQT_LVL_SEL_BIT]
        |=> skip_q == $past(ext_irq_pin_i))
        else $error("pin test wrong with high level selected");

    a_read_ctl_one: assert property (
        op_go && op_i == irqt_pkg::IRQT_OP_RD_IC1 |=> acc_we_q && !aux_we_q
        && acc_q == $past(ic1_q) ##1 !acc_we_q || $past(op_go))
        else $error("control one read wrong");

    a_write_ctl_one: assert property (
        op_go && op_i == irqt_pkg::IRQT_OP_WR_IC1 |=> ic1_q == $past(acc_i) && !acc_we_q)
        else $error("control one write wrong");

    a_ps_write_both: assert property (
        s_ps_write |=> ps_cnt == $past(ab_val) && ps_rld_q == $past(ab_val))
        else $error("prescaler write did not load count and reload");

    a_t1_read_pair: assert property (
        op_go && op_i == irqt_pkg::IRQT_OP_RD_T1 |=> {aux_q, acc_q} == $past(t1_cnt)
        && acc_we_q && aux_we_q)
        else $error("timer one read wrong");

    a_t1h_keeps_count: assert property (
        op_go && op_i == irqt_pkg::IRQT_OP_WR_T1H && !t1_tick
        |=> t1h_q == $past(ab_val) && t1_cnt == $past(t1_cnt))
        else $error("high reload write disturbed timer one");

    a_skip_squashes: assert property (
        s_skip_taken |=> !acc_we_q && !aux_we_q && !skip_q && $stable(ic1_q)
        && $stable(tc1_q) && $stable(irq_en_q))
        else $error("skipped word had an effect");
endmodule

/* File: test_irqt_ops.sv */
`timescale 1ns/1ps
module test_irqt_ops;
    // Stimulus
    logic clk_i;
    logic rst_n_i;
    logic op_valid_i;
    irqt_pkg::irqt_op_e op_i;
    irqt_pkg::irqt_nib_t acc_i;
    irqt_pkg::irqt_nib_t aux_i;
    logic ext0_req_i;
    logic ext_irq_pin_i;
    logic prescaler_run_i;
    logic timer_one_run_i;
    // Observed
    irqt_pkg::irqt_nib_t acc_o;
    logic acc_we_o;
    irqt_pkg::irqt_nib_t aux_o;
    logic aux_we_o;
    logic skip_o;
    logic global_irq_enable_flag_o;
    logic ext0_request_flag_o;
    irqt_pkg::irqt_nib_t irq_control_one_o;
    irqt_pkg::irqt_nib_t irq_control_two_o;
    irqt_pkg::irqt_nib_t ext_irq_control_o;
    logic timer_aux_control_o;
    irqt_pkg::irqt_nib_t timer_control_one_o;
    irqt_pkg::irqt_nib_t timer_control_two_o;
    irqt_pkg::irqt_nib_t timer_control_five_o;
    irqt_pkg::irqt_nib_t timer_control_six_o;
    irqt_pkg::irqt_byte_t prescaler_count_o;
    irqt_pkg::irqt_byte_t prescaler_reload_o;
    logic prescaler_underflow_o;
    irqt_pkg::irqt_byte_t timer_one_count_o;
    irqt_pkg::irqt_byte_t timer_one_low_reload_o;
    irqt_pkg::irqt_byte_t timer_one_high_reload_o;
    logic timer_one_underflow_o;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;

    irqt_ops uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i), .op_i(op_i),
        .acc_i(acc_i), .aux_i(aux_i), .ext0_req_i(ext0_req_i),
        .ext_irq_pin_i(ext_irq_pin_i), .prescaler_run_i(prescaler_run_i),
        .timer_one_run_i(timer_one_run_i), .acc_o(acc_o), .acc_we_o(acc_we_o),
        .aux_o(aux_o), .aux_we_o(aux_we_o), .skip_o(skip_o),
        .global_irq_enable_flag_o(global_irq_enable_flag_o),
        .ext0_request_flag_o(ext0_request_flag_o),
        .irq_control_one_o(irq_control_one_o), .irq_control_two_o(irq_control_two_o),
        .ext_irq_control_o(ext_irq_control_o), .timer_aux_control_o(timer_aux_control_o),
        .timer_control_one_o(timer_control_one_o),
        .timer_control_two_o(timer_control_two_o),
        .timer_control_five_o(timer_control_five_o),
        .timer_control_six_o(timer_control_six_o),
        .prescaler_count_o(prescaler_count_o), .prescaler_reload_o(prescaler_reload_o),
        .prescaler_underflow_o(prescaler_underflow_o),
        .timer_one_count_o(timer_one_count_o),
        .timer_one_low_reload_o(timer_one_low_reload_o),
        .timer_one_high_reload_o(timer_one_high_reload_o),
        .timer_one_underflow_o(timer_one_underflow_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // A hang would otherwise leave the run without a verdict
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds the word for exactly one taking edge, then samples once it has landed
    task automatic issue(input irqt_pkg::irqt_op_e code, input logic [3:0] a,
                         input logic [3:0] b);
        @(posedge clk_i);
        op_valid_i <= 1'b1;
        op_i <= code;
        acc_i <= a;
        aux_i <= b;
        @(posedge clk_i);
        op_valid_i <= 1'b0;
        #1;
    endtask

    task automatic ext0_pulse();
        @(posedge clk_i);
        ext0_req_i <= 1'b1;
        @(posedge clk_i);
        ext0_req_i <= 1'b0;
        #1;
    endtask

    task automatic t_irq_enable();
        issue(irqt_pkg::IRQT_OP_EI, 4'h0, 4'h0);
        chk({7'h00, global_irq_enable_flag_o}, 8'h01);
        issue(irqt_pkg::IRQT_OP_DI, 4'hF, 4'hF);
        chk({7'h00, global_irq_enable_flag_o}, 8'h00);
        $display("test irq_enable done");
    endtask

    // All pairs written first, then read back, so crosstalk between registers shows
    task automatic t_ctl_regs();
        irqt_pkg::irqt_op_e wr[7];
        irqt_pkg::irqt_op_e rd[7];
        wr = '{irqt_pkg::IRQT_OP_WR_IC1, irqt_pkg::IRQT_OP_WR_IC2, irqt_pkg::IRQT_OP_WR_EXC,
               irqt_pkg::IRQT_OP_WR_TC1, irqt_pkg::IRQT_OP_WR_TC2, irqt_pkg::IRQT_OP_WR_TC5,
               irqt_pkg::IRQT_OP_WR_TC6};
        rd = '{irqt_pkg::IRQT_OP_RD_IC1, irqt_pkg::IRQT_OP_RD_IC2, irqt_pkg::IRQT_OP_RD_EXC,
               irqt_pkg::IRQT_OP_RD_TC1, irqt_pkg::IRQT_OP_RD_TC2, irqt_pkg::IRQT_OP_RD_TC5,
               irqt_pkg::IRQT_OP_RD_TC6};
        for (int i = 0; i < 7; i++) begin
            issue(wr[i], 4'(4'h8 + i), 4'h0);
        end
        chk({4'h0, irq_control_two_o}, 8'h09);
        chk({4'h0, timer_control_six_o}, 8'h0E);
        chk({timer_control_one_o, ext_irq_control_o}, 8'hBA);
        chk({timer_control_five_o, timer_control_two_o}, 8'hDC);
        for (int i = 0; i < 7; i++) begin
            issue(rd[i], 4'h0, 4'h0);
            chk({3'h0, acc_we_o, acc_o}, {3'h0, 1'b1, 4'(4'h8 + i)});
        end
        issue(irqt_pkg::IRQT_OP_WR_AUX, 4'hE, 4'h0);
        chk({7'h00, timer_aux_control_o}, 8'h00);
        issue(irqt_pkg::IRQT_OP_WR_AUX, 4'h1, 4'h0);
        chk({7'h00, timer_aux_control_o}, 8'h01);
        $display("test ctl_regs done");
    endtask

    task automatic t_ext0_skip();
        issue(irqt_pkg::IRQT_OP_WR_IC1, 4'h1, 4'h0);
        ext0_pulse();
        issue(irqt_pkg::IRQT_OP_SKEXT0, 4'h0, 4'h0);
        chk({6'h00, skip_o, ext0_request_flag_o}, 8'h01);
        issue(irqt_pkg::IRQT_OP_WR_IC1, 4'h0, 4'h0);
        issue(irqt_pkg::IRQT_OP_SKEXT0, 4'h0, 4'h0);
        chk({6'h00, skip_o, ext0_request_flag_o}, 8'h02);
        // Skipped word must leave control one alone
        issue(irqt_pkg::IRQT_OP_WR_IC1, 4'hF, 4'h0);
        chk({3'h0, skip_o, irq_control_one_o}, 8'h00);
        issue(irqt_pkg::IRQT_OP_SKEXT0, 4'h0, 4'h0);
        chk({6'h00, skip_o, ext0_request_flag_o}, 8'h00);
        $display("test ext0_skip done");
    endtask

    task automatic t_pin_skip();
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            issue(irqt_pkg::IRQT_OP_WR_EXC, {1'b0, c[1], 2'h0}, 4'h0);
            @(posedge clk_i);
            ext_irq_pin_i <= c[0];
            issue(irqt_pkg::IRQT_OP_SKPIN, 4'h0, 4'h0);
            chk({7'h00, skip_o}, {7'h00, c[0] == c[1]});
            issue(irqt_pkg::IRQT_OP_EI, 4'h0, 4'h0);
            chk({6'h00, skip_o, global_irq_enable_flag_o}, {7'h00, c[0] != c[1]});
            issue(irqt_pkg::IRQT_OP_DI, 4'h0, 4'h0);
        end
        $display("test pin_skip done");
    endtask

    task automatic t_prescaler();
        issue(irqt_pkg::IRQT_OP_WR_PS, 4'h5, 4'hA);
        chk(prescaler_count_o, 8'hA5);
        chk(prescaler_reload_o, 8'hA5);
        @(posedge clk_i);
        prescaler_run_i <= 1'b1;
        @(posedge clk_i);
        prescaler_run_i <= 1'b0;
        #1;
        chk(prescaler_count_o, 8'hA4);
        issue(irqt_pkg::IRQT_OP_RD_PS, 4'h0, 4'h0);
        chk({aux_o, acc_o}, 8'hA4);
        chk({6'h00, aux_we_o, acc_we_o}, 8'h03);
        @(posedge clk_i);
        #1;
        chk({6'h00, aux_we_o, acc_we_o}, 8'h00);
        $display("test prescaler done");
    endtask

    task automatic t_timer_one();
        issue(irqt_pkg::IRQT_OP_WR_T1, 4'hC, 4'h3);
        chk(timer_one_count_o, 8'h3C);
        chk(timer_one_low_reload_o, 8'h3C);
        issue(irqt_pkg::IRQT_OP_WR_T1H, 4'h1, 4'h7);
        chk(timer_one_high_reload_o, 8'h71);
        chk(timer_one_count_o, 8'h3C);
        chk(timer_one_low_reload_o, 8'h3C);
        issue(irqt_pkg::IRQT_OP_RD_T1, 4'h0, 4'h0);
        chk({aux_o, acc_o}, 8'h3C);
        // Zero counts with zero reloads: one prescaler tick underflows both in turn
        issue(irqt_pkg::IRQT_OP_WR_PS, 4'h0, 4'h0);
        issue(irqt_pkg::IRQT_OP_WR_T1, 4'h0, 4'h0);
        @(posedge clk_i);
        prescaler_run_i <= 1'b1;
        timer_one_run_i <= 1'b1;
        @(posedge clk_i);
        prescaler_run_i <= 1'b0;
        #1;
        chk({6'h00, prescaler_underflow_o, timer_one_underflow_o}, 8'h02);
        @(posedge clk_i);
        #1;
        chk({6'h00, prescaler_underflow_o, timer_one_underflow_o}, 8'h01);
        chk(timer_one_count_o, 8'h00);
        @(posedge clk_i);
        timer_one_run_i <= 1'b0;
        #1;
        chk({6'h00, prescaler_underflow_o, timer_one_underflow_o}, 8'h00);
        $display("test timer_one done");
    endtask

    initial begin
        rst_n_i = 1'b0;
        op_valid_i = 1'b0;
        op_i = irqt_pkg::IRQT_OP_NONE;
        acc_i = 4'h0;
        aux_i = 4'h0;
        ext0_req_i = 1'b0;
        ext_irq_pin_i = 1'b1;
        prescaler_run_i = 1'b0;
        timer_one_run_i = 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk(prescaler_count_o, 8'hFF);
        chk({6'h00, skip_o, global_irq_enable_flag_o}, 8'h00);
        t_irq_enable();
        t_ctl_regs();
        t_ext0_skip();
        t_pin_skip();
        t_prescaler();
        t_timer_one();
        close_out();
    end
endmodule
